// *** verilog/dual_timer_defines.svh ***
// Offsets, field positions, reset values and prescale counts of the dual timer
//
// What this block does
// [R01] Cascade bit joins both timers into 32 bits
// [R02] Cascaded: high control ignored, low control rules
// [R03] Cascaded match reported on high flag
// [R04] Cascaded period is high:low period words
// [R05] Cascaded count: high word upper, low lower
// [R06] Cascaded 32-bit match raises the event
// [R07] Converter trigger only cascaded or high alone
// [R08] Single timers count synchronously only
// [R09] Run bit 15 starts and stops timer
// [R10] Idle-stop bit 13 halts timer in idle
// [R11] Source field bits 9-8 picks external clock
// [R12] Clock-source bit 1 picks external or internal
// [R13] Gate bit 6 gates internal clock only
// [R14] Prescale bits 5-4 divide by 1/8/64/256
// [R15] Control write while running clears prescaler
// [R16] Unimplemented control bits ignore writes, read zero
// [R17] Software configures fully before setting run
// [R18] Control bits read/write, reset to zero
// [R19] Period match sets flag, count returns zero
// [R20] Cascaded low carry increments high word
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

`define OFF_LOW_CTRL     4'h0
`define OFF_HIGH_CTRL    4'h1
`define OFF_COUNT_LOW    4'h2
`define OFF_COUNT_HIGH   4'h3
`define OFF_PERIOD_LOW   4'h4
`define OFF_PERIOD_HIGH  4'h5
`define OFF_MATCH_FLAGS  4'h6

`define BIT_RUN          15
`define BIT_IDLE_STOP    13
`define FLD_EXT_SRC_HI   9
`define FLD_EXT_SRC_LO   8
`define BIT_GATE         6
`define FLD_PRESC_HI     5
`define FLD_PRESC_LO     4
`define BIT_CASCADE      3
`define BIT_CLK_SRC      1
`define BIT_LOW_FLAG     0
`define BIT_HIGH_FLAG    1

`define LOW_CTRL_MASK    16'hA37A
`define HIGH_CTRL_MASK   16'hA372
`define CTRL_RESET       16'h0000
`define COUNT_RESET      16'h0000
`define PERIOD_RESET     16'hFFFF
`define COUNT_MAX        16'hFFFF

`define PRESC_LAST_DIV1   8'h00
`define PRESC_LAST_DIV8   8'h07
`define PRESC_LAST_DIV64  8'h3F
`define PRESC_LAST_DIV256 8'hFF

`endif

// *** verilog/dual_timer_pkg.sv ***
// Types shared by the dual timer files
package dual_timer_pkg;

   typedef enum logic [1:0] {
      SRC_SECONDARY_OSC = 2'h0,
      SRC_PARTNER_PIN   = 2'h1,
      SRC_LOW_POWER_RC  = 2'h2,
      SRC_GENERIC_PIN   = 2'h3
   } ext_src_e;

   typedef enum logic [1:0] {
      PRESC_DIV1   = 2'h0,
      PRESC_DIV8   = 2'h1,
      PRESC_DIV64  = 2'h2,
      PRESC_DIV256 = 2'h3
   } prescale_e;

   typedef logic [15:0] word_t;

endpackage : dual_timer_pkg

// *** verilog/timer_tick_gen.sv ***
// Clock source selection, gating and prescaler of one timer
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.svh"

module timer_tick_gen #(
   parameter int PRESC_W = 8
) (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     clk_en,
   // Control
   input  wire logic                     run,
   input  wire logic                     clk_src_ext,
   input  wire dual_timer_pkg::ext_src_e  ext_sel,
   input  wire logic                     gate_en,
   input  wire dual_timer_pkg::prescale_e presc_sel,
   input  wire logic                     presc_clear,
   // Synchronised inputs
   input  wire logic [3:0]               ext_edge,
   input  wire logic                     gate_level,
   // Prescaled count enable
   output logic                          tick
);

   function automatic logic [PRESC_W-1:0] presc_last(input dual_timer_pkg::prescale_e sel);
      case (sel)
         dual_timer_pkg::PRESC_DIV8:   presc_last = PRESC_W'(`PRESC_LAST_DIV8);
         dual_timer_pkg::PRESC_DIV64:  presc_last = PRESC_W'(`PRESC_LAST_DIV64);
         dual_timer_pkg::PRESC_DIV256: presc_last = PRESC_W'(`PRESC_LAST_DIV256);
         default:                      presc_last = PRESC_W'(`PRESC_LAST_DIV1);
      endcase
   endfunction : presc_last

   logic [PRESC_W-1:0] presc_q;
   logic [PRESC_W-1:0] presc_d;
   logic               ext_pulse;
   logic               int_pulse;
   logic               src_pulse;
   logic               wrap;

   // External edges always pass the synchroniser; no free-running mode
   assign ext_pulse = ext_edge[ext_sel]; // [R11] [R08]
   assign int_pulse = gate_en ? gate_level : 1'b1; // [R13]
   assign src_pulse = run & (clk_src_ext ? ext_pulse : int_pulse); // [R12] [R09]
   assign wrap      = presc_q == presc_last(presc_sel); // [R14]
   assign tick      = src_pulse & wrap & ~presc_clear;
   assign presc_d   = presc_clear ? '0 : // [R15]
                      (src_pulse ? (wrap ? '0 : PRESC_W'(presc_q + 1'b1)) : presc_q);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         presc_q <= '0;
      end else if (clk_en) begin
         presc_q <= presc_d;
      end
   end

endmodule : timer_tick_gen
`default_nettype wire

// *** verilog/cascadable_dual_timer.sv ***
// Pair of 16-bit timers that cascade into one 32-bit timer
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.svh"

module cascadable_dual_timer (
   // Clock, reset, freeze
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Device power state
   input  wire logic        idle_mode,
   // Clock source pins
   input  wire logic        generic_external_clock_in,
   input  wire logic        partner_external_clock_in,
   input  wire logic        low_power_rc_oscillator,
   input  wire logic        secondary_oscillator,
   // Gate pins
   input  wire logic        low_gate_in,
   input  wire logic        high_gate_in,
   // Events
   output logic             low_match_flag,
   output logic             high_match_flag,
   output logic             adc_trigger
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   dual_timer_pkg::word_t lctl_q;
   dual_timer_pkg::word_t lctl_d;
   dual_timer_pkg::word_t hctl_q;
   dual_timer_pkg::word_t hctl_d;
   dual_timer_pkg::word_t cnt_lo_q;
   dual_timer_pkg::word_t cnt_lo_d;
   dual_timer_pkg::word_t cnt_hi_q;
   dual_timer_pkg::word_t cnt_hi_d;
   dual_timer_pkg::word_t per_lo_q;
   dual_timer_pkg::word_t per_lo_d;
   dual_timer_pkg::word_t per_hi_q;
   dual_timer_pkg::word_t per_hi_d;
   logic                  low_flag_q;
   logic                  low_flag_d;
   logic                  high_flag_q;
   logic                  high_flag_d;
   logic                  adc_q;
   logic                  adc_d;
   logic [15:0]           rdata_q;
   logic [15:0]           rdata_d;
   logic [5:0]            pin_meta_q;
   logic [5:0]            pin_sync_q;
   logic [5:0]            pin_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Next value of one counting word on a prescaled tick
   function automatic logic [15:0] bump(input logic [15:0] cnt, input logic hit);
      bump = hit ? `COUNT_RESET : 16'(cnt + 16'h0001);
   endfunction : bump

   function automatic logic run_now(input logic [15:0] ctl, input logic idle);
      run_now = ctl[`BIT_RUN] & ~(idle & ctl[`BIT_IDLE_STOP]);
   endfunction : run_now

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [5:0] pin_raw;
   logic [3:0] ext_edge;
   logic       low_gate_lvl;
   logic       high_gate_lvl;
   logic       low_gate_fall;
   logic       high_gate_fall;

   // Index order matches the source select code
   assign pin_raw = {high_gate_in, low_gate_in,
                     generic_external_clock_in, low_power_rc_oscillator,
                     partner_external_clock_in, secondary_oscillator};

   // Rising edges only; pins are resampled on ref_clk
   assign ext_edge      = pin_sync_q[3:0] & ~pin_prev_q[3:0]; // [R08]
   assign low_gate_lvl  = pin_sync_q[4];
   assign high_gate_lvl = pin_sync_q[5];
   assign low_gate_fall  = pin_prev_q[4] & ~pin_sync_q[4];
   assign high_gate_fall = pin_prev_q[5] & ~pin_sync_q[5];

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic wr_lctl;
   logic wr_hctl;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_per_lo;
   logic wr_per_hi;
   logic wr_flags;

   assign wr_lctl   = reg_wr & (reg_addr == `OFF_LOW_CTRL);
   assign wr_hctl   = reg_wr & (reg_addr == `OFF_HIGH_CTRL);
   assign wr_cnt_lo = reg_wr & (reg_addr == `OFF_COUNT_LOW);
   assign wr_cnt_hi = reg_wr & (reg_addr == `OFF_COUNT_HIGH);
   assign wr_per_lo = reg_wr & (reg_addr == `OFF_PERIOD_LOW);
   assign wr_per_hi = reg_wr & (reg_addr == `OFF_PERIOD_HIGH);
   assign wr_flags  = reg_wr & (reg_addr == `OFF_MATCH_FLAGS);

   ////////////////////////////////////////////////////////////////////////////
   // Mode and run state

   logic cascade;
   logic low_run;
   logic high_run;
   logic low_clear;
   logic high_clear;
   logic low_gated;
   logic high_gated;

   assign cascade  = lctl_q[`BIT_CASCADE]; // [R01]
   assign low_run  = run_now(lctl_q, idle_mode); // [R09] [R10]
   // High control has no say while cascaded
   assign high_run = ~cascade & run_now(hctl_q, idle_mode); // [R02] [R09] [R10]

   assign low_clear  = wr_lctl & lctl_q[`BIT_RUN]; // [R15]
   assign high_clear = wr_hctl & hctl_q[`BIT_RUN] & ~cascade; // [R15] [R02]

   assign low_gated  = lctl_q[`BIT_GATE] & ~lctl_q[`BIT_CLK_SRC]; // [R13]
   assign high_gated = hctl_q[`BIT_GATE] & ~hctl_q[`BIT_CLK_SRC]; // [R13]

   ////////////////////////////////////////////////////////////////////////////
   // Tick generators

   logic low_tick;
   logic high_tick;

   timer_tick_gen #(
      .PRESC_W (8)
   ) u_low_tick (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .clk_en      (clk_en),
      .run         (low_run),
      .clk_src_ext (lctl_q[`BIT_CLK_SRC]),
      .ext_sel     (dual_timer_pkg::ext_src_e'(lctl_q[`FLD_EXT_SRC_HI:`FLD_EXT_SRC_LO])),
      .gate_en     (low_gated),
      .presc_sel   (dual_timer_pkg::prescale_e'(lctl_q[`FLD_PRESC_HI:`FLD_PRESC_LO])),
      .presc_clear (low_clear),
      .ext_edge    (ext_edge),
      .gate_level  (low_gate_lvl),
      .tick        (low_tick)
   );

   timer_tick_gen #(
      .PRESC_W (8)
   ) u_high_tick (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .clk_en      (clk_en),
      .run         (high_run),
      .clk_src_ext (hctl_q[`BIT_CLK_SRC]),
      .ext_sel     (dual_timer_pkg::ext_src_e'(hctl_q[`FLD_EXT_SRC_HI:`FLD_EXT_SRC_LO])),
      .gate_en     (high_gated),
      .presc_sel   (dual_timer_pkg::prescale_e'(hctl_q[`FLD_PRESC_HI:`FLD_PRESC_LO])),
      .presc_clear (high_clear),
      .ext_edge    (ext_edge),
      .gate_level  (high_gate_lvl),
      .tick        (high_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Period compare

   logic [31:0] cat_cnt;
   logic [31:0] cat_per;
   logic        cat_hit;
   logic        lo_hit;
   logic        hi_hit;
   logic        lo_carry;

   assign cat_cnt  = {cnt_hi_q, cnt_lo_q}; // [R05]
   assign cat_per  = {per_hi_q, per_lo_q}; // [R04]
   assign cat_hit  = cat_cnt == cat_per; // [R06]
   assign lo_hit   = cnt_lo_q == per_lo_q;
   assign hi_hit   = cnt_hi_q == per_hi_q;
   assign lo_carry = cnt_lo_q == `COUNT_MAX; // [R20]

   ////////////////////////////////////////////////////////////////////////////
   // Count words

   logic [15:0] lo_step;
   logic [15:0] hi_step;

   assign lo_step = cascade ? bump(cnt_lo_q, cat_hit) : bump(cnt_lo_q, lo_hit); // [R19]
   // Upper word follows the low word's carry while cascaded
   assign hi_step = cascade ?
                    (cat_hit ? `COUNT_RESET : 16'(cnt_hi_q + {15'h0000, lo_carry})) : // [R20]
                    bump(cnt_hi_q, hi_hit); // [R19]

   // Software load wins over counting
   assign cnt_lo_d = wr_cnt_lo ? reg_wdata : (low_tick ? lo_step : cnt_lo_q);
   assign cnt_hi_d = wr_cnt_hi ? reg_wdata :
                     (((cascade & low_tick) | high_tick) ? hi_step : cnt_hi_q); // [R05]

   assign per_lo_d = wr_per_lo ? reg_wdata : per_lo_q;
   assign per_hi_d = wr_per_hi ? reg_wdata : per_hi_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   assign lctl_d = wr_lctl ? (reg_wdata & `LOW_CTRL_MASK) : lctl_q; // [R16] [R18]
   assign hctl_d = wr_hctl ? (reg_wdata & `HIGH_CTRL_MASK) : hctl_q; // [R16] [R18]

   ////////////////////////////////////////////////////////////////////////////
   // Events and flags

   logic low_evt;
   logic high_evt;
   logic low_gate_evt;
   logic high_gate_evt;
   logic low_flag_clr;
   logic high_flag_clr;

   // Gate falling edge ends an accumulation window
   assign low_gate_evt  = low_gated & low_run & low_gate_fall;
   assign high_gate_evt = high_gated & high_run & high_gate_fall;

   assign low_evt  = ~cascade & ((low_tick & lo_hit) | low_gate_evt); // [R19]
   assign high_evt = cascade ? ((low_tick & cat_hit) | low_gate_evt) : // [R03] [R06]
                     ((high_tick & hi_hit) | high_gate_evt); // [R19]

   // Converter trigger never comes from the low timer alone
   assign adc_d = cascade ? (low_tick & cat_hit) : (high_tick & hi_hit); // [R07]

   assign low_flag_clr  = wr_flags & reg_wdata[`BIT_LOW_FLAG];
   assign high_flag_clr = wr_flags & reg_wdata[`BIT_HIGH_FLAG];

   // Set wins over a write-one clear in the same cycle
   assign low_flag_d  = (low_flag_q & ~low_flag_clr) | low_evt;
   assign high_flag_d = (high_flag_q & ~high_flag_clr) | high_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [15:0] rd_mux;

   assign rd_mux = (reg_addr == `OFF_LOW_CTRL)    ? lctl_q :
                   (reg_addr == `OFF_HIGH_CTRL)   ? hctl_q :
                   (reg_addr == `OFF_COUNT_LOW)   ? cnt_lo_q :
                   (reg_addr == `OFF_COUNT_HIGH)  ? cnt_hi_q :
                   (reg_addr == `OFF_PERIOD_LOW)  ? per_lo_q :
                   (reg_addr == `OFF_PERIOD_HIGH) ? per_hi_q :
                   (reg_addr == `OFF_MATCH_FLAGS) ? {14'h0000, high_flag_q, low_flag_q} :
                   16'h0000;

   // Data stands only in the cycle after the strobe
   assign rdata_d = reg_rd ? rd_mux : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Flip-flops

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_meta_q <= 6'h00;
         pin_sync_q <= 6'h00;
         pin_prev_q <= 6'h00;
      end else if (clk_en) begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lctl_q <= `CTRL_RESET; // [R18]
         hctl_q <= `CTRL_RESET; // [R18]
      end else if (clk_en) begin
         lctl_q <= lctl_d;
         hctl_q <= hctl_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_lo_q <= `COUNT_RESET;
         cnt_hi_q <= `COUNT_RESET;
         per_lo_q <= `PERIOD_RESET;
         per_hi_q <= `PERIOD_RESET;
      end else if (clk_en) begin
         cnt_lo_q <= cnt_lo_d;
         cnt_hi_q <= cnt_hi_d;
         per_lo_q <= per_lo_d;
         per_hi_q <= per_hi_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         low_flag_q  <= 1'b0;
         high_flag_q <= 1'b0;
         adc_q       <= 1'b0;
         rdata_q     <= 16'h0000;
      end else if (clk_en) begin
         low_flag_q  <= low_flag_d;
         high_flag_q <= high_flag_d;
         adc_q       <= adc_d;
         rdata_q     <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata       = rdata_q;
   assign low_match_flag  = low_flag_q;
   assign high_match_flag = high_flag_q;
   assign adc_trigger     = adc_q;

endmodule : cascadable_dual_timer
`default_nettype wire

// *** verif/cascadable_dual_timer_sva.sv ***
// Port assertions of the cascadable dual timer
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.svh"

module cascadable_dual_timer_sva (
   // Clock, reset, freeze
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Power state and pins
   input wire logic        idle_mode,
   input wire logic        generic_external_clock_in,
   input wire logic        partner_external_clock_in,
   input wire logic        low_power_rc_oscillator,
   input wire logic        secondary_oscillator,
   input wire logic        low_gate_in,
   input wire logic        high_gate_in,
   // Events
   input wire logic        low_match_flag,
   input wire logic        high_match_flag,
   input wire logic        adc_trigger
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   wire rd_go = reg_rd && clk_en;
   wire wr_go = reg_wr && clk_en;
   wire clr_lo = wr_go && reg_addr == `OFF_MATCH_FLAGS && reg_wdata[`BIT_LOW_FLAG];
   wire clr_hi = wr_go && reg_addr == `OFF_MATCH_FLAGS && reg_wdata[`BIT_HIGH_FLAG];

   sequence s_ctrl_wr;
      wr_go && reg_addr == `OFF_LOW_CTRL;
   endsequence
   sequence s_ctrl_rd;
      rd_go && reg_addr == `OFF_LOW_CTRL;
   endsequence

   // Write, one idle slot, then read back, as the bus tasks issue them
   a_ctrl_readback: assert property (s_ctrl_wr ##1 !wr_go ##1 s_ctrl_rd |=>
      reg_rdata == ($past(reg_wdata, 3) & `LOW_CTRL_MASK)) else $error("control readback wrong");
   a_low_mask: assert property (s_ctrl_rd |=> (reg_rdata & ~`LOW_CTRL_MASK) == 16'h0000)
      else $error("low control reserved bits set");
   a_high_mask: assert property (rd_go && reg_addr == `OFF_HIGH_CTRL |=>
      (reg_rdata & ~`HIGH_CTRL_MASK) == 16'h0000) else $error("high control reserved bits set");
   a_unmapped_read: assert property (rd_go && reg_addr > `OFF_MATCH_FLAGS |=>
      reg_rdata == 16'h0000) else $error("unmapped read not zero");
   a_rdata_idle: assert property (!$past(rd_go) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   a_flags_read: assert property (rd_go && reg_addr == `OFF_MATCH_FLAGS |=>
      reg_rdata == {14'h0000, $past(high_match_flag), $past(low_match_flag)})
      else $error("flag register disagrees with flags");
   a_low_hold: assert property (low_match_flag && !clr_lo |=> low_match_flag)
      else $error("low flag dropped");
   a_high_hold: assert property (high_match_flag && !clr_hi |=> high_match_flag)
      else $error("high flag dropped");
   a_adc_flag: assert property (adc_trigger |-> high_match_flag)
      else $error("trigger without high flag");
endmodule : cascadable_dual_timer_sva
`default_nettype wire

// *** verif/cascadable_dual_timer_bench.sv ***
// Self-checking bench of the cascadable dual timer
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.svh"

module cascadable_dual_timer_bench;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        idle_mode = 1'b0;
   logic [3:0]  src_pins = 4'h0;
   logic        low_gate = 1'b1;
   logic        clk_en = 1'b1;
   logic        low_match_flag;
   logic        high_match_flag;
   logic        adc_trigger;
   int          fails = 0;
   int          checked = 0;
   int          cyc = 0;
   int          adc_n = 0;
   int          n;
   int          a0;
   logic [15:0] rv;
   logic [15:0] rows [8][3] = '{'{16'h0004, 16'h1234, 16'h1234}, '{16'h0005, 16'hABCD, 16'hABCD},
      '{16'h0002, 16'h5A5A, 16'h5A5A}, '{16'h0003, 16'h00FF, 16'h00FF},
      '{16'h0007, 16'hFFFF, 16'h0000}, '{16'h000F, 16'h1234, 16'h0000},
      '{16'h0001, 16'hFFFF, 16'hA372}, '{16'h0000, 16'hFFFF, 16'hA37A}};
   logic [15:0] rst_exp [7] = '{`CTRL_RESET, `CTRL_RESET, `COUNT_RESET, `COUNT_RESET,
      `PERIOD_RESET, `PERIOD_RESET, 16'h0000};
   logic [15:0] divs [4] = '{16'h0002, 16'h0010, 16'h0080, 16'h0200};
   logic [15:0] quiet [2] = '{16'h8040, 16'hA000};

   cascadable_dual_timer cascadable_dual_timer_i (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .idle_mode(idle_mode), .generic_external_clock_in(src_pins[3]),
      .partner_external_clock_in(src_pins[1]), .low_power_rc_oscillator(src_pins[2]),
      .secondary_oscillator(src_pins[0]), .low_gate_in(low_gate), .high_gate_in(1'b1),
      .low_match_flag(low_match_flag), .high_match_flag(high_match_flag),
      .adc_trigger(adc_trigger));

   always #25 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cyc++;
      if (adc_trigger === 1'b1) adc_n++;
      if (cyc == 30000) begin
         fails++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Compared %0d values, %0d mismatches", checked, fails);
      if (fails == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_adc(output int k);
      k = 0;
      do begin
         @(posedge ref_clk);
         #1 k++;
      end while (adc_trigger !== 1'b1 && k < 600);
   endtask : wait_adc

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      for (int i = 0; i < 8; i++) begin
         wr(rows[i][0][3:0], rows[i][1]);
         rd(rows[i][0][3:0], rv);
         check(rv, rows[i][2]);
      end
      // Reset while the low timer runs
      do_reset();
      for (int i = 0; i < 7; i++) begin
         rd(i[3:0], rv);
         check(rv, rst_exp[i]);
      end
      // Low timer alone: flag but no trigger
      a0 = adc_n;
      wr(`OFF_PERIOD_LOW, 16'h0002);
      wr(`OFF_LOW_CTRL, 16'h8000);
      repeat (8) @(posedge ref_clk);
      wr(`OFF_LOW_CTRL, 16'h0000);
      rd(`OFF_MATCH_FLAGS, rv);
      check(rv, 16'h0001);
      check(16'(low_match_flag), 16'h0001);
      check(16'(adc_n - a0), 16'h0000);
      wr(`OFF_MATCH_FLAGS, 16'h0003);
      // High timer alone, every prescale ratio
      wr(`OFF_PERIOD_HIGH, 16'h0001);
      for (int p = 0; p < 4; p++) begin
         wr(`OFF_HIGH_CTRL, {10'h200, p[1:0], 4'h0});
         wait_adc(n);
         wait_adc(n);
         check(n[15:0], divs[p]);
         wr(`OFF_HIGH_CTRL, 16'h0000);
      end
      // Control writes while running keep the prescaler from ticking
      wr(`OFF_PERIOD_HIGH, 16'h0000);
      wr(`OFF_COUNT_HIGH, 16'h0000);
      wr(`OFF_HIGH_CTRL, 16'h8010);
      wr(`OFF_HIGH_CTRL, 16'h8010);
      a0 = adc_n;
      repeat (6) wr(`OFF_HIGH_CTRL, 16'h8010);
      check(16'(adc_n - a0), 16'h0000);
      // Cascade: carry into the high word, no match on the low word alone
      wr(`OFF_LOW_CTRL, 16'h0008);
      wr(`OFF_HIGH_CTRL, 16'h8030);
      wr(`OFF_PERIOD_HIGH, 16'h0001);
      wr(`OFF_PERIOD_LOW, 16'hFFFF);
      wr(`OFF_COUNT_HIGH, 16'h0000);
      wr(`OFF_COUNT_LOW, 16'hFFFD);
      wr(`OFF_MATCH_FLAGS, 16'h0003);
      wr(`OFF_LOW_CTRL, 16'h8008);
      repeat (8) @(posedge ref_clk);
      wr(`OFF_LOW_CTRL, 16'h0008);
      rd(`OFF_COUNT_HIGH, rv);
      check(rv, 16'h0001);
      rd(`OFF_MATCH_FLAGS, rv);
      check(rv, 16'h0000);
      // Cascade: full 32-bit match
      wr(`OFF_COUNT_HIGH, 16'h0000);
      wr(`OFF_COUNT_LOW, 16'hFFFE);
      wr(`OFF_PERIOD_LOW, 16'h0001);
      a0 = adc_n;
      wr(`OFF_LOW_CTRL, 16'h8008);
      repeat (8) @(posedge ref_clk);
      wr(`OFF_LOW_CTRL, 16'h0008);
      rd(`OFF_MATCH_FLAGS, rv);
      check(rv, 16'h0002);
      rd(`OFF_COUNT_HIGH, rv);
      check(rv, 16'h0000);
      check(16'(adc_n - a0), 16'h0001);
      wr(`OFF_HIGH_CTRL, 16'h0000);
      wr(`OFF_LOW_CTRL, 16'h0000);
      // Period above the pulse count so no match wraps it
      wr(`OFF_PERIOD_LOW, 16'h00FF);
      // Each extended source counts the pulses on its own pin
      for (int s = 0; s < 4; s++) begin
         wr(`OFF_COUNT_LOW, 16'h0000);
         wr(`OFF_LOW_CTRL, {6'h20, s[1:0], 8'h02});
         repeat (5) begin
            repeat (3) @(posedge ref_clk);
            src_pins[s] <= 1'b1;
            repeat (3) @(posedge ref_clk);
            src_pins[s] <= 1'b0;
         end
         repeat (5) @(posedge ref_clk);
         wr(`OFF_LOW_CTRL, 16'h0000);
         rd(`OFF_COUNT_LOW, rv);
         check(rv, 16'h0005);
      end
      // Closed gate and idle stop both hold the count
      low_gate <= 1'b0;
      idle_mode <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int q = 0; q < 2; q++) begin
         wr(`OFF_COUNT_LOW, 16'h0000);
         wr(`OFF_LOW_CTRL, quiet[q]);
         repeat (10) @(posedge ref_clk);
         wr(`OFF_LOW_CTRL, 16'h0000);
         rd(`OFF_COUNT_LOW, rv);
         check(rv, 16'h0000);
      end
      // Write made while frozen is lost
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(`OFF_LOW_CTRL, 16'h8000);
      clk_en <= 1'b1;
      rd(`OFF_LOW_CTRL, rv);
      check(rv, 16'h0000);
      final_report();
   end
endmodule : cascadable_dual_timer_bench

bind cascadable_dual_timer cascadable_dual_timer_sva cascadable_dual_timer_sva_i (
   .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .idle_mode(idle_mode), .generic_external_clock_in(generic_external_clock_in),
   .partner_external_clock_in(partner_external_clock_in),
   .low_power_rc_oscillator(low_power_rc_oscillator),
   .secondary_oscillator(secondary_oscillator), .low_gate_in(low_gate_in),
   .high_gate_in(high_gate_in), .low_match_flag(low_match_flag),
   .high_match_flag(high_match_flag), .adc_trigger(adc_trigger));
`default_nettype wire
